// ==== logic/msr_params.svh ====
// Offsets, field positions, reset values and timing figures of the mode switch sequencer
`ifndef MSR_PARAMS_SVH
`define MSR_PARAMS_SVH

// Clock rate in Hz
`define MSR_CLK_HZ        100000000

// Times in milliseconds
`define MSR_DEB_MS        20
`define MSR_ARM_MS        3000
`define MSR_PHASE_MS      2000
`define MSR_FW_WIN_MS     10000
`define MSR_CONF_MS       1000
`define MSR_BLINK_SLOW_MS 500
`define MSR_BLINK_FAST_MS 125

// Trial time in hours
`define MSR_TRIAL_HOURS   72

// Steady phases needed for a factory reset
`define MSR_FR_STEADY     4'h6

// Delivery-state values
`define MSR_NODE_DEFAULT  8'h02
`define MSR_IP_DEFAULT    32'h00000000

// Register byte offsets
`define MSR_OFF_CTRL      5'h00
`define MSR_OFF_STATUS    5'h04
`define MSR_OFF_TRIAL     5'h08
`define MSR_OFF_NODE      5'h0C
`define MSR_OFF_IP        5'h10

// Field positions
`define MSR_CTRL_ORST     0
`define MSR_ST_RUN        4
`define MSR_ST_OPT        5
`define MSR_ST_EXPIRED    6
`define MSR_ST_FWOK       7

`endif

// ==== logic/msr_pkg.sv ====
// Types of the mode switch sequencer
package msr_pkg;

  typedef enum logic [3:0] {
    BOOT     = 4'h0,
    IDLE     = 4'h1,
    HOLD     = 4'h2,
    ARMED    = 4'h3,
    TIP      = 4'h4,
    ORST     = 4'h5,
    POST     = 4'h6,
    RELOAD   = 4'h7,
    FR_TIP   = 4'h8,
    FCLR     = 4'h9,
    FR_CONF  = 4'hA,
    FW_OFFER = 4'hB,
    FW_TIP   = 4'hC,
    FW_XFER  = 4'hD,
    FW_ERASE = 4'hE,
    FW_END   = 4'hF
  } msr_state_t;

endpackage : msr_pkg

// ==== logic/msr_sequencer.sv ====
// Mode switch reset sequencer with Avalon-MM register slave
//
// How it works
// - Overall reset erases user memory, card untouched
// - Three seconds at reset position arms, steady
// - Armed quick tip starts overall reset, flashing
// - Steady stop light marks overall reset done
// - Bus overall reset only in STOP
// - After overall reset enable option card functions
// - Reload default project, card light while loading
// - Factory reset clears RAM, node 2, IP zero
// - Long hold: blink, steady, then alternating phases
// - Release after sixth steady, tip, run light on
// - Other release gives only overall reset
// - Command file factory reset also honoured
// - Firmware name is pb plus six digits
// - Differing firmware at boot: alternate error lights
// - Equal firmware version: no update
// - Transfer: alternate blink, card light steady
// - Success all but run light steady, failure fast blink
// - Every successful firmware update includes overall reset
// - Missing option card: error light, 72 h, stop
// - Check card after power-on and overall reset
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "msr_params.svh"

module msr_sequencer #(
  parameter logic [31:0] DEB_CYC   = 32'(64'(`MSR_DEB_MS) * 64'(`MSR_CLK_HZ) / 64'd1000),
  parameter logic [31:0] ARM_CYC   = 32'(64'(`MSR_ARM_MS) * 64'(`MSR_CLK_HZ) / 64'd1000),
  parameter logic [31:0] PHASE_CYC = 32'(64'(`MSR_PHASE_MS) * 64'(`MSR_CLK_HZ) / 64'd1000),
  parameter logic [31:0] FWWIN_CYC = 32'(64'(`MSR_FW_WIN_MS) * 64'(`MSR_CLK_HZ) / 64'd1000),
  parameter logic [31:0] CONF_CYC  = 32'(64'(`MSR_CONF_MS) * 64'(`MSR_CLK_HZ) / 64'd1000),
  parameter logic [31:0] SLOW_CYC  = 32'(64'(`MSR_BLINK_SLOW_MS) * 64'(`MSR_CLK_HZ) / 64'd1000),
  parameter logic [31:0] FAST_CYC  = 32'(64'(`MSR_BLINK_FAST_MS) * 64'(`MSR_CLK_HZ) / 64'd1000),
  parameter logic [63:0] TRIAL_CYC = 64'(`MSR_TRIAL_HOURS) * 64'd3600 * 64'(`MSR_CLK_HZ)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Mode switch positions
  input  wire logic        swRun,
  input  wire logic        swStop,
  input  wire logic        swMres,
  // Card slot
  input  wire logic        keyCardPresent,
  input  wire logic        defaultProjOnCard,
  input  wire logic        fwFilePresent,
  input  wire logic [63:0] fwName,
  input  wire logic        fwVersionDiffers,
  input  wire logic        cmdFactoryReset,
  output logic             cardCheckReq,
  // Memory and firmware handshakes
  output logic             userEraseReq,
  input  wire logic        userEraseDone,
  output logic             ramClearReq,
  input  wire logic        ramClearDone,
  output logic             reloadReq,
  input  wire logic        reloadDone,
  output logic             fwXferReq,
  input  wire logic        fwXferDone,
  input  wire logic        fwXferOk,
  // Configuration and mode
  output logic [7:0]       nodeAddr,
  output logic [31:0]      ipAddr,
  output logic             optionEnable,
  output logic             runMode,
  // Indicators
  output logic             powerLed,
  output logic             stopLed,
  output logic             runLed,
  output logic             errorLed,
  output logic             forcedLed,
  output logic             cardLed
);

  if (DEB_CYC == 32'h0 || ARM_CYC == 32'h0 || PHASE_CYC == 32'h0 || FWWIN_CYC == 32'h0 ||
      CONF_CYC == 32'h0 || SLOW_CYC == 32'h0 || FAST_CYC == 32'h0 || TRIAL_CYC == 64'h0)
  begin : gCheck
    $error("msr_sequencer: every timing count must be at least one cycle");
  end

  msr_pkg::msr_state_t state_q;
  msr_pkg::msr_state_t state_d;
  logic [31:0]         tmr_q;
  logic [31:0]         phaseTmr_q;
  logic [3:0]          steadyCnt_q;
  logic                inSteady_q;
  logic [2:0]          swRaw;
  logic [2:0]          swDeb;
  logic                posRun;
  logic                posStop;
  logic                posMres;
  logic                nameOk;
  logic                orstCmd_q;
  logic                waitReq_q;
  logic [31:0]         readData_q;
  logic [31:0]         rdMux;
  logic                busWr;
  logic [31:0]         slowTmr_q;
  logic [31:0]         fastTmr_q;
  logic                blinkSlow_q;
  logic                blinkFast_q;
  logic [63:0]         trialLeft_q;
  logic                trialExpired_q;
  logic                optionsActive_q;
  logic                fwOk_q;
  logic                runMode_q;
  logic [7:0]          nodeAddr_q;
  logic [31:0]         ipAddr_q;
  logic                userEraseReq_q;
  logic                ramClearReq_q;
  logic                reloadReq_q;
  logic                fwXferReq_q;
  logic                cardCheckReq_q;
  logic                powerLed_q;
  logic                stopLed_q;
  logic                runLed_q;
  logic                errorLed_q;
  logic                forcedLed_q;
  logic                cardLed_q;

  // Switch inputs: two-stage synchroniser and hold-off counter per position
  assign swRaw = {swMres, swStop, swRun};

  for (genvar i = 0; i < 3; i++)
  begin : gDeb
    logic        meta_q;
    logic        sync_q;
    logic        stable_q;
    logic [31:0] cnt_q;
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        meta_q   <= 1'b0;
        sync_q   <= 1'b0;
        stable_q <= 1'b0;
        cnt_q    <= 32'h0;
      end
      else
      begin
        meta_q <= swRaw[i];
        sync_q <= meta_q;
        if (sync_q == stable_q)
          cnt_q <= 32'h0;
        else if (cnt_q >= DEB_CYC - 32'h1)
        begin
          stable_q <= sync_q;
          cnt_q    <= 32'h0;
        end
        else
          cnt_q <= cnt_q + 32'h1;
      end
    end
    assign swDeb[i] = stable_q;
  end

  assign posRun  = swDeb[0];
  assign posStop = swDeb[1];
  assign posMres = swDeb[2];

  // Firmware file name: two letters then six decimal digits
  function automatic logic fw_name_ok(input logic [63:0] nm);
    logic ok;
    ok = (nm[63:56] == 8'h70) && (nm[55:48] == 8'h62);
    for (int k = 0; k < 6; k++)
      ok = ok && (nm[k*8 +: 8] >= 8'h30) && (nm[k*8 +: 8] <= 8'h39);
    return ok;
  endfunction : fw_name_ok

  assign nameOk = fw_name_ok(fwName);

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      msr_pkg::BOOT:
        if (tmr_q >= DEB_CYC + 32'h2)
          state_d = (posStop && fwFilePresent && nameOk && fwVersionDiffers)
                    ? msr_pkg::FW_OFFER : msr_pkg::IDLE;
      msr_pkg::IDLE:
        if (cmdFactoryReset && !runMode_q)
          state_d = msr_pkg::FCLR;
        else if (orstCmd_q && !runMode_q)
          state_d = msr_pkg::ORST;
        else if (posMres && !runMode_q)
          state_d = msr_pkg::HOLD;
      msr_pkg::HOLD:
        if (!posMres)
        begin
          if (steadyCnt_q == 4'h0)
            state_d = msr_pkg::IDLE;
          else if (steadyCnt_q == 4'h1)
            state_d = msr_pkg::ARMED;
          else if (steadyCnt_q == `MSR_FR_STEADY)
            state_d = msr_pkg::FR_TIP;
          else
            state_d = msr_pkg::ORST;
        end
      msr_pkg::ARMED:
        if (orstCmd_q)
          state_d = msr_pkg::ORST;
        else if (posMres)
          state_d = msr_pkg::TIP;
        else if (posRun)
          state_d = msr_pkg::IDLE;
      msr_pkg::TIP:
        if (posMres && tmr_q >= ARM_CYC - 32'h1)
          state_d = msr_pkg::HOLD;
        else if (!posMres)
          state_d = msr_pkg::ORST;
      msr_pkg::ORST:
        if (userEraseDone)
          state_d = msr_pkg::POST;
      msr_pkg::POST:
        state_d = defaultProjOnCard ? msr_pkg::RELOAD : msr_pkg::IDLE;
      msr_pkg::RELOAD:
        if (reloadDone)
          state_d = msr_pkg::IDLE;
      msr_pkg::FR_TIP:
        if (posMres)
          state_d = msr_pkg::FCLR;
        else if (posRun)
          state_d = msr_pkg::ORST;
      msr_pkg::FCLR:
        if (ramClearDone)
          state_d = msr_pkg::FR_CONF;
      msr_pkg::FR_CONF:
        if (tmr_q >= CONF_CYC - 32'h1)
          state_d = msr_pkg::IDLE;
      msr_pkg::FW_OFFER:
        if (posMres)
          state_d = msr_pkg::FW_TIP;
        else if (tmr_q >= FWWIN_CYC - 32'h1)
          state_d = msr_pkg::IDLE;
      msr_pkg::FW_TIP:
        if (posStop)
          state_d = msr_pkg::FW_XFER;
      msr_pkg::FW_XFER:
        if (fwXferDone)
          state_d = fwXferOk ? msr_pkg::FW_ERASE : msr_pkg::FW_END;
      msr_pkg::FW_ERASE:
        if (userEraseDone)
          state_d = msr_pkg::FW_END;
      msr_pkg::FW_END:
        state_d = msr_pkg::FW_END;
    endcase
  end

  // State and dwell timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= msr_pkg::BOOT;
      tmr_q   <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q)
        tmr_q <= 32'h0;
      else if (tmr_q != 32'hFFFFFFFF)
        tmr_q <= tmr_q + 32'h1;
    end
  end

  // Long hold: first steady after arm time, then blink and steady phases
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phaseTmr_q  <= 32'h0;
      steadyCnt_q <= 4'h0;
      inSteady_q  <= 1'b0;
    end
    else if (state_q != msr_pkg::HOLD)
    begin
      phaseTmr_q  <= 32'h0;
      steadyCnt_q <= 4'h0;
      inSteady_q  <= 1'b0;
    end
    else if (steadyCnt_q == 4'h0)
    begin
      if (phaseTmr_q >= ARM_CYC - 32'h1)
      begin
        phaseTmr_q  <= 32'h0;
        steadyCnt_q <= 4'h1;
        inSteady_q  <= 1'b1;
      end
      else
        phaseTmr_q <= phaseTmr_q + 32'h1;
    end
    else if (phaseTmr_q >= PHASE_CYC - 32'h1)
    begin
      phaseTmr_q <= 32'h0;
      inSteady_q <= !inSteady_q;
      if (!inSteady_q && steadyCnt_q != 4'hF)
        steadyCnt_q <= steadyCnt_q + 4'h1;
    end
    else
      phaseTmr_q <= phaseTmr_q + 32'h1;
  end

  // Blink generators
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slowTmr_q   <= 32'h0;
      fastTmr_q   <= 32'h0;
      blinkSlow_q <= 1'b0;
      blinkFast_q <= 1'b0;
    end
    else
    begin
      slowTmr_q <= (slowTmr_q >= SLOW_CYC - 32'h1) ? 32'h0 : slowTmr_q + 32'h1;
      fastTmr_q <= (fastTmr_q >= FAST_CYC - 32'h1) ? 32'h0 : fastTmr_q + 32'h1;
      if (slowTmr_q >= SLOW_CYC - 32'h1)
        blinkSlow_q <= !blinkSlow_q;
      if (fastTmr_q >= FAST_CYC - 32'h1)
        blinkFast_q <= !blinkFast_q;
    end
  end

  // Option card activation and trial timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      optionsActive_q <= 1'b0;
      trialLeft_q     <= TRIAL_CYC;
      trialExpired_q  <= 1'b0;
    end
    else
    begin
      if (state_q == msr_pkg::POST && keyCardPresent)
        optionsActive_q <= 1'b1;
      else if (state_q == msr_pkg::FCLR && ramClearDone)
        optionsActive_q <= 1'b0;
      if (!optionsActive_q || keyCardPresent)
      begin
        trialLeft_q    <= TRIAL_CYC;
        trialExpired_q <= 1'b0;
      end
      else if (trialLeft_q != 64'h0)
        trialLeft_q <= trialLeft_q - 64'h1;
      else
        trialExpired_q <= 1'b1;
    end
  end

  // Mode, handshake requests and firmware result
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      runMode_q      <= 1'b0;
      userEraseReq_q <= 1'b0;
      ramClearReq_q  <= 1'b0;
      reloadReq_q    <= 1'b0;
      fwXferReq_q    <= 1'b0;
      cardCheckReq_q <= 1'b0;
      fwOk_q         <= 1'b0;
    end
    else
    begin
      runMode_q      <= state_d == msr_pkg::IDLE && posRun && !trialExpired_q;
      userEraseReq_q <= state_d == msr_pkg::ORST || state_d == msr_pkg::FW_ERASE;
      ramClearReq_q  <= state_d == msr_pkg::FCLR;
      reloadReq_q    <= state_d == msr_pkg::RELOAD;
      fwXferReq_q    <= state_d == msr_pkg::FW_XFER;
      cardCheckReq_q <= (state_q == msr_pkg::BOOT && state_d != msr_pkg::BOOT) ||
                        state_q == msr_pkg::POST;
      if (state_q == msr_pkg::FW_XFER && fwXferDone)
        fwOk_q <= fwXferOk;
    end
  end

  // Indicators
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      powerLed_q  <= 1'b0;
      stopLed_q   <= 1'b0;
      runLed_q    <= 1'b0;
      errorLed_q  <= 1'b0;
      forcedLed_q <= 1'b0;
      cardLed_q   <= 1'b0;
    end
    else
    begin
      powerLed_q  <= 1'b1;
      stopLed_q   <= 1'b1;
      runLed_q    <= 1'b0;
      errorLed_q  <= optionsActive_q && !keyCardPresent;
      forcedLed_q <= 1'b0;
      cardLed_q   <= 1'b0;
      unique case (state_q)
        msr_pkg::BOOT, msr_pkg::ARMED, msr_pkg::TIP, msr_pkg::FR_TIP:
          stopLed_q <= 1'b1;
        msr_pkg::IDLE:
        begin
          stopLed_q <= !runMode_q;
          runLed_q  <= runMode_q;
        end
        msr_pkg::HOLD:
          stopLed_q <= inSteady_q || blinkSlow_q;
        msr_pkg::ORST, msr_pkg::POST, msr_pkg::FCLR:
          stopLed_q <= blinkFast_q;
        msr_pkg::RELOAD:
          cardLed_q <= 1'b1;
        msr_pkg::FR_CONF:
          runLed_q <= 1'b1;
        msr_pkg::FW_OFFER, msr_pkg::FW_TIP:
        begin
          errorLed_q  <= blinkSlow_q;
          forcedLed_q <= !blinkSlow_q;
        end
        msr_pkg::FW_XFER, msr_pkg::FW_ERASE:
        begin
          errorLed_q  <= blinkSlow_q;
          forcedLed_q <= !blinkSlow_q;
          cardLed_q   <= 1'b1;
        end
        msr_pkg::FW_END:
        begin
          powerLed_q  <= fwOk_q || blinkFast_q;
          stopLed_q   <= fwOk_q || blinkFast_q;
          errorLed_q  <= fwOk_q || blinkFast_q;
          forcedLed_q <= fwOk_q || blinkFast_q;
          cardLed_q   <= fwOk_q || blinkFast_q;
        end
      endcase
    end
  end

  // Avalon-MM slave: answer one cycle after the request is seen
  assign busWr = avs_write && !waitReq_q;

  always_comb
  begin
    rdMux = 32'h0;
    unique case (avs_address)
      `MSR_OFF_STATUS:
      begin
        rdMux[3:0]             = state_q;
        rdMux[`MSR_ST_RUN]     = runMode_q;
        rdMux[`MSR_ST_OPT]     = optionsActive_q;
        rdMux[`MSR_ST_EXPIRED] = trialExpired_q;
        rdMux[`MSR_ST_FWOK]    = fwOk_q;
      end
      `MSR_OFF_TRIAL:
        rdMux = trialLeft_q[47:16];
      `MSR_OFF_NODE:
        rdMux[7:0] = nodeAddr_q;
      `MSR_OFF_IP:
        rdMux = ipAddr_q;
      default:
        rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      waitReq_q  <= 1'b1;
      readData_q <= 32'h0;
      orstCmd_q  <= 1'b0;
    end
    else
    begin
      waitReq_q <= !((avs_read || avs_write) && waitReq_q);
      if (avs_read && waitReq_q)
        readData_q <= rdMux;
      orstCmd_q <= busWr && avs_address == `MSR_OFF_CTRL &&
                   avs_writedata[`MSR_CTRL_ORST];
    end
  end

  // Node and Ethernet addresses
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nodeAddr_q <= `MSR_NODE_DEFAULT;
      ipAddr_q   <= `MSR_IP_DEFAULT;
    end
    else if (state_q == msr_pkg::FCLR && ramClearDone)
    begin
      nodeAddr_q <= `MSR_NODE_DEFAULT;
      ipAddr_q   <= `MSR_IP_DEFAULT;
    end
    else if (busWr && avs_address == `MSR_OFF_NODE)
      nodeAddr_q <= avs_writedata[7:0];
    else if (busWr && avs_address == `MSR_OFF_IP)
      ipAddr_q <= avs_writedata;
  end

  assign avs_readdata    = readData_q;
  assign avs_waitrequest = waitReq_q;
  assign cardCheckReq    = cardCheckReq_q;
  assign userEraseReq    = userEraseReq_q;
  assign ramClearReq     = ramClearReq_q;
  assign reloadReq       = reloadReq_q;
  assign fwXferReq       = fwXferReq_q;
  assign nodeAddr        = nodeAddr_q;
  assign ipAddr          = ipAddr_q;
  assign optionEnable    = optionsActive_q;
  assign runMode         = runMode_q;
  assign powerLed        = powerLed_q;
  assign stopLed         = stopLed_q;
  assign runLed          = runLed_q;
  assign errorLed        = errorLed_q;
  assign forcedLed       = forcedLed_q;
  assign cardLed         = cardLed_q;

  // Checks
  sequence armTipBack;
    state_q == msr_pkg::TIP && !posMres && tmr_q < ARM_CYC;
  endsequence

  sequence eraseRuns;
    state_q == msr_pkg::ORST && userEraseReq_q;
  endsequence

  armedSteady_a: assert property (@(posedge clk) disable iff (rst)
    state_q == msr_pkg::ARMED |=> stopLed_q)
    else $error("stop light not steady while armed");

  tipStarts_a: assert property (@(posedge clk) disable iff (rst)
    armTipBack |=> eraseRuns)
    else $error("quick tip did not start overall reset");

  eraseEnds_a: assert property (@(posedge clk) disable iff (rst)
    state_q == msr_pkg::ORST && userEraseDone |=> state_q == msr_pkg::POST ##1 cardCheckReq_q)
    else $error("overall reset end not followed by card check");

  busRunIgnored_a: assert property (@(posedge clk) disable iff (rst)
    orstCmd_q && runMode_q && state_q == msr_pkg::IDLE |=> state_q != msr_pkg::ORST)
    else $error("bus overall reset accepted in RUN");

  optionOn_a: assert property (@(posedge clk) disable iff (rst)
    state_q == msr_pkg::POST && keyCardPresent |=> optionEnable)
    else $error("option functions not enabled");

  reloadLight_a: assert property (@(posedge clk) disable iff (rst)
    state_q == msr_pkg::RELOAD ##1 state_q == msr_pkg::RELOAD |-> cardLed_q && reloadReq_q)
    else $error("card light or reload request missing");

  factoryVals_a: assert property (@(posedge clk) disable iff (rst)
    state_q == msr_pkg::FCLR && ramClearDone |=> nodeAddr_q == 8'h02 && ipAddr_q == 32'h0)
    else $error("delivery addresses not restored");

  wrongRelease_a: assert property (@(posedge clk) disable iff (rst)
    state_q == msr_pkg::HOLD && !posMres && steadyCnt_q > 4'h1 && steadyCnt_q != 4'h6
    |=> state_q == msr_pkg::ORST)
    else $error("bad release did not fall back to overall reset");

  sameFw_a: assert property (@(posedge clk) disable iff (rst)
    state_q == msr_pkg::BOOT && !fwVersionDiffers |=> state_q != msr_pkg::FW_OFFER)
    else $error("update offered for equal version");

  trialDown_a: assert property (@(posedge clk) disable iff (rst)
    optionsActive_q && !keyCardPresent && trialLeft_q != 64'h0 |=>
    trialLeft_q == $past(trialLeft_q) - 64'h1)
    else $error("trial timer not counting down");

endmodule : msr_sequencer

// ==== verif/msr_mem_model.sv ====
// Handshake answers of user memory, RAM, project and firmware store
`timescale 1ns/10ps
module msr_mem_model #(parameter int DLY = 12) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Requests and answers
  input  wire logic [3:0] req,
  output logic      [3:0] done
);
  logic [7:0] cnt [4];
  // One done pulse per request, DLY+1 cycles after it rises
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done <= 4'h0;
      for (int k = 0; k < 4; k++) cnt[k] <= 8'h00;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        done[k] <= req[k] & (cnt[k] == 8'(DLY));
        if (!req[k]) cnt[k] <= 8'h00;
        else if (cnt[k] <= 8'(DLY)) cnt[k] <= cnt[k] + 8'h01;
      end
    end
  end
endmodule : msr_mem_model

// ==== verif/tb_top.sv ====
// Self-checking bench of the mode switch sequencer
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, ipAddr;
  logic        avs_waitrequest, swRun = 1'b0, swStop = 1'b1, swMres = 1'b0;
  logic        keyCard = 1'b1, projOnCard = 1'b1, fwDiff = 1'b0, cmdFr = 1'b0;
  logic        fwFile = 1'b1, xferOk = 1'b1;
  logic [4:0]  ledsA;
  logic [63:0] fwName = "pb000001";
  logic [3:0]  req, done;
  logic [7:0]  nodeAddr;
  logic        cardCheckReq, optionEnable, runMode, powerLed, stopLed, runLed;
  logic        errorLed, forcedLed, cardLed, ccSeen = 1'b0, xferSeen = 1'b0, prev = 1'b0;
  logic [31:0] expQ [$];
  int          failures = 0, checks = 0, cyc = 0, seed = 3, flips = 0;

  // Shortened timing so every sequence fits the run
  localparam logic [31:0] DEB = 32'h4, ARM = 32'h32, PHS = 32'h28, WIN = 32'h64, CNF = 32'hA;
  localparam logic [31:0] SLW = 32'h4, FST = 32'h2;
  localparam logic [63:0] TRL = 64'hC8;

  msr_sequencer #(.DEB_CYC(DEB), .ARM_CYC(ARM), .PHASE_CYC(PHS), .FWWIN_CYC(WIN),
    .CONF_CYC(CNF), .SLOW_CYC(SLW), .FAST_CYC(FST), .TRIAL_CYC(TRL)) u_dut (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .swRun, .swStop, .swMres, .keyCardPresent(keyCard),
    .defaultProjOnCard(projOnCard), .fwFilePresent(fwFile), .fwName, .fwVersionDiffers(fwDiff),
    .cmdFactoryReset(cmdFr), .cardCheckReq, .userEraseReq(req[0]), .userEraseDone(done[0]),
    .ramClearReq(req[1]), .ramClearDone(done[1]), .reloadReq(req[2]), .reloadDone(done[2]),
    .fwXferReq(req[3]), .fwXferDone(done[3]), .fwXferOk(xferOk), .nodeAddr, .ipAddr,
    .optionEnable, .runMode, .powerLed, .stopLed, .runLed, .errorLed, .forcedLed, .cardLed);
  msr_mem_model u_mem (.clk, .rst, .req, .done);

  always #5 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Watchers: read data, sticky flags, flashing, timeout
  always @(posedge clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0)
      cmp("readdata", expQ.pop_front(), avs_readdata);
    if (cardCheckReq === 1'b1) ccSeen <= 1'b1;
    if (req[3] === 1'b1) xferSeen <= 1'b1;
    if (req[0] === 1'b1 && stopLed !== prev) flips <= flips + 1;
    prev <= stopLed;
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    if (!wr) expQ.push_back(d);
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic waitReq(input int k, input logic v);
    for (int i = 0; i < 400 && req[k] !== v; i++) @(posedge clk);
    cmp("request", v, req[k]);
  endtask : waitReq

  task automatic sw(input logic r, input logic s, input logic m, input int n);
    @(posedge clk);
    swRun <= r;
    swStop <= s;
    swMres <= m;
    tick(n);
  endtask : sw

  task automatic hold8(input int w);
    repeat (8)
    begin
      @(negedge clk);
      cmp("steady", 1'b1, w ? errorLed ^ forcedLed : stopLed);
    end
  endtask : hold8

  initial
  begin
    tick(12);
    rst <= 1'b0;
    cmp("nodeAddr", 8'h02, nodeAddr);
    cmp("ipAddr", 32'h0, ipAddr);
    tick(12);
    bus(1'b0, 5'h04, 32'h1);
    bus(1'b1, 5'h14, $random(seed));
    bus(1'b0, 5'h14, 32'h0);
    bus(1'b1, 5'h00, 32'h1 | $random(seed));
    waitReq(0, 1'b1);
    waitReq(0, 1'b0);
    cmp("flashing", 1'b1, flips > 0);
    waitReq(2, 1'b1);
    tick(2);
    cmp("cardLed", 1'b1, cardLed);
    waitReq(2, 1'b0);
    tick(3);
    cmp("cardLed", 1'b0, cardLed);
    cmp("optionEnable", 1'b1, optionEnable);
    cmp("cardCheck", 1'b1, ccSeen);
    projOnCard <= 1'b0;
    hold8(0);
    $display("test bus overall reset done");
    sw(1'b0, 1'b0, 1'b1, 70);
    hold8(0);
    sw(1'b0, 1'b1, 1'b0, 20);
    sw(1'b0, 1'b0, 1'b1, 15);
    sw(1'b0, 1'b1, 1'b0, 0);
    waitReq(0, 1'b1);
    waitReq(0, 1'b0);
    tick(5);
    cmp("reloadReq", 1'b0, req[2]);
    $display("test switch overall reset done");
    sw(1'b1, 1'b0, 1'b0, 20);
    cmp("runMode", 1'b1, runMode);
    bus(1'b1, 5'h00, 32'h1);
    tick(10);
    cmp("userEraseReq", 1'b0, req[0]);
    keyCard <= 1'b0;
    tick(4);
    cmp("errorLed", 1'b1, errorLed);
    tick(100);
    cmp("runMode", 1'b1, runMode);
    tick(120);
    cmp("runMode", 1'b0, runMode);
    keyCard <= 1'b1;
    tick(20);
    cmp("errorLed", 1'b0, errorLed);
    cmp("runMode", 1'b1, runMode);
    $display("test run and trial done");
    sw(1'b0, 1'b1, 1'b0, 20);
    bus(1'b1, 5'h0C, $random(seed));
    bus(1'b1, 5'h10, $random(seed));
    cmdFr <= 1'b1;
    tick(1);
    cmdFr <= 1'b0;
    waitReq(1, 1'b1);
    waitReq(1, 1'b0);
    tick(30);
    cmp("nodeAddr", 8'h02, nodeAddr);
    cmp("ipAddr", 32'h0, ipAddr);
    sw(1'b0, 1'b0, 1'b1, 150);
    sw(1'b0, 1'b1, 1'b0, 0);
    waitReq(0, 1'b1);
    cmp("ramClearReq", 1'b0, req[1]);
    waitReq(0, 1'b0);
    tick(20);
    sw(1'b0, 1'b0, 1'b1, 470);
    sw(1'b0, 1'b1, 1'b0, 20);
    sw(1'b0, 1'b0, 1'b1, 15);
    sw(1'b0, 1'b1, 1'b0, 0);
    waitReq(1, 1'b1);
    for (int i = 0; i < 60 && runLed !== 1'b1; i++) @(posedge clk);
    cmp("runLed", 1'b1, runLed);
    $display("test factory reset done");
    cmp("xferSeen", 1'b0, xferSeen);
    fwDiff <= 1'b1;
    fwName <= {"pb00", 24'h303030 | (24'($random(seed)) & 24'h070707), "1"};
    tick(40);
    rst <= 1'b1;
    tick(12);
    rst <= 1'b0;
    tick(12);
    hold8(1);
    sw(1'b0, 1'b0, 1'b1, 15);
    sw(1'b0, 1'b1, 1'b0, 0);
    waitReq(3, 1'b1);
    tick(2);
    cmp("cardLed", 1'b1, cardLed);
    hold8(1);
    waitReq(0, 1'b1);
    waitReq(0, 1'b0);
    tick(4);
    cmp("leds", 5'h1F, {powerLed, stopLed, errorLed, forcedLed, cardLed});
    bus(1'b0, 5'h04, 32'h8F);
    $display("test firmware update done");
    xferOk <= 1'b0;
    rst <= 1'b1;
    tick(12);
    rst <= 1'b0;
    tick(20);
    sw(1'b0, 1'b0, 1'b1, 15);
    sw(1'b0, 1'b1, 1'b0, 0);
    waitReq(3, 1'b1);
    waitReq(3, 1'b0);
    tick(4);
    bus(1'b0, 5'h04, 32'h0F);
    @(negedge clk) ledsA = {powerLed, stopLed, errorLed, forcedLed, cardLed};
    repeat (2) @(negedge clk);
    cmp("fastBlink", {27'h0, ~ledsA}, {powerLed, stopLed, errorLed, forcedLed, cardLed});
    $display("test firmware failure done");
    report_and_stop();
  end
endmodule : tb_top
